// [design/ows_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ows_fifo #(
    parameter int W = 7,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic do_wr;
    logic do_rd;

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((wr_q[AW] != rd_q[AW])
                        && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem[rd_q[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // Storage; no reset needed, contents are guarded by the pointers
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_FIFO_OCCUPANCY: assert property (
        (AW+1)'(wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo occupancy above depth");

endmodule
`default_nettype wire

// [design/ows_pkg.sv]
// Shared constants and types for the single-wire dimming receiver.
// Assumes a 200 MHz system clock; every time below is converted to cycles.
package ows_pkg;

    // System clock period
    localparam int CLK_PERIOD_PS = 5000;

    // Least start interval before a byte, rounded up to whole cycles
    localparam int T_START_NS = 2000;
    localparam int START_CYC = (T_START_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;

    // Least end-of-stream interval closing a byte, rounded up
    localparam int END_OF_STREAM_TIME_NS = 2000;
    localparam int EOS_CYC = (END_OF_STREAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;

    // Internal acknowledge validity delay after the last falling edge
    localparam int T_ACK_VALID_NS = 4000;
    localparam int ACK_VALID_CYC = (T_ACK_VALID_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;

    // Longest acknowledge pulse, rounded down
    localparam int T_ACK_PULSE_NS = 512000;
    localparam int ACK_PULSE_CYC = T_ACK_PULSE_NS * 1000 / CLK_PERIOD_PS;

    // Slowest bit rate; one low or high phase longer than this bit period is a timeout
    localparam int MIN_BIT_RATE = 1700;
    localparam int T_BIT_MAX_NS = 1000000000 / MIN_BIT_RATE;
    localparam int BIT_MAX_CYC = T_BIT_MAX_NS * 1000 / CLK_PERIOD_PS;

    // Widths
    localparam int CNT_W = 18;
    localparam int BYTE_BITS = 8;
    localparam int LEVEL_W = 5;
    localparam int SUB_W = 2;
    localparam int FB_W = 8;
    localparam int FIFO_W = SUB_W + LEVEL_W;
    localparam int FIFO_DEPTH = 16;

    // Data byte field positions
    localparam int ACK_REQ_POS = 7;
    localparam int SUB_HI_POS = 6;
    localparam int SUB_LO_POS = 5;
    localparam int LEVEL_MSB_POS = 4;

    // Reset values
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h1F;
    // Device address: value is arbitrary
    localparam logic [BYTE_BITS-1:0] DEV_ADDR_DEFAULT = 8'h5A;

    // Receiver states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_EOS,
        ST_ACKWAIT,
        ST_ACK,
        ST_ERR
    } ows_state_t;

endpackage

// [design/ows_rx.sv]
// Single-wire dimming command receiver with open-drain acknowledge.
// Assumes ctrl_in is synchronous to clk and the line idles high via pull-up.
// Functional notes
// - Frame is address byte then data byte, each sent MSB first.
// - Data byte: bit 7 ack request, bits 6-5 sub-address, 4-0 level.
// - Line already high before address byte needs no start interval.
// - Each byte ends with at least 2 us end-of-stream interval.
// - Bit period runs from falling edge to next falling edge.
// - High time at least twice low time decodes as one.
// - Low time at least twice high time decodes as zero.
// - Ack only with request flag, matching address, sixteen good bits.
// - Ack pulls line low after validity delay, at most 512 us.
// - Ack is open-drain low only; line never driven high.
// - Level code selects one of 32 pseudo-log reference steps.
// - Stored level resets to full scale.
// - Decoder works from 1.7 to 160 kbit/s without setup.
`timescale 1ns/1ps
`default_nettype none
module ows_rx
    import ows_pkg::*;
#(
    parameter int ACK_PULSE_CYCLES = ACK_PULSE_CYC,
    parameter int BIT_MAX_CYCLES = BIT_MAX_CYC,
    parameter logic [BYTE_BITS-1:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control pin, open drain
    input wire logic ctrl_in,
    output logic ctrl_out,
    output logic ctrl_oe_n,
    // Level consumer
    input wire logic level_hold,
    output logic [LEVEL_W-1:0] level_code,
    output logic [SUB_W-1:0] sub_address,
    output logic [FB_W-1:0] feedback_reference_mv,
    // Status
    output logic frame_ok,
    output logic frame_drop,
    output logic frame_err,
    output logic rx_busy
);

    // Reference step in millivolts for each level code
    function automatic logic [FB_W-1:0] ows_fb_mv(
        input logic [LEVEL_W-1:0] code);
        case (code)
            5'h00: ows_fb_mv = 8'h00;
            5'h01: ows_fb_mv = 8'h05;
            5'h02: ows_fb_mv = 8'h08;
            5'h03: ows_fb_mv = 8'h0B;
            5'h04: ows_fb_mv = 8'h0E;
            5'h05: ows_fb_mv = 8'h11;
            5'h06: ows_fb_mv = 8'h14;
            5'h07: ows_fb_mv = 8'h17;
            5'h08: ows_fb_mv = 8'h1A;
            5'h09: ows_fb_mv = 8'h1D;
            5'h0A: ows_fb_mv = 8'h20;
            5'h0B: ows_fb_mv = 8'h23;
            5'h0C: ows_fb_mv = 8'h26;
            5'h0D: ows_fb_mv = 8'h2C;
            5'h0E: ows_fb_mv = 8'h32;
            5'h0F: ows_fb_mv = 8'h38;
            5'h10: ows_fb_mv = 8'h3E;
            5'h11: ows_fb_mv = 8'h44;
            5'h12: ows_fb_mv = 8'h4A;
            5'h13: ows_fb_mv = 8'h50;
            5'h14: ows_fb_mv = 8'h56;
            5'h15: ows_fb_mv = 8'h5C;
            5'h16: ows_fb_mv = 8'h62;
            5'h17: ows_fb_mv = 8'h68;
            5'h18: ows_fb_mv = 8'h74;
            5'h19: ows_fb_mv = 8'h80;
            5'h1A: ows_fb_mv = 8'h8C;
            5'h1B: ows_fb_mv = 8'h98;
            5'h1C: ows_fb_mv = 8'hA4;
            5'h1D: ows_fb_mv = 8'hB0;
            5'h1E: ows_fb_mv = 8'hBC;
            default: ows_fb_mv = 8'hC8;
        endcase
    endfunction

    // True when a exceeds b and is at least twice b
    function automatic logic ows_dominates(
        input logic [CNT_W-1:0] a,
        input logic [CNT_W-1:0] b);
        ows_dominates = (a > b) && ({1'b0, a} >= {b, 1'b0});
    endfunction

    ows_state_t state_q;
    logic in_q;
    logic prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] low_len_q;
    logic [CNT_W-1:0] ack_len_q;
    logic [3:0] bit_cnt_q;
    logic byte_idx_q;
    logic [BYTE_BITS-1:0] shreg_q;
    logic [BYTE_BITS-1:0] addr_q;
    logic push_q;
    logic [FIFO_W-1:0] push_data_q;
    logic ok_q;
    logic drop_q;
    logic err_q;
    logic busy_q;
    logic oe_n_q;
    logic out_q;
    logic [LEVEL_W-1:0] level_q;
    logic [SUB_W-1:0] sub_q;
    logic [FB_W-1:0] fb_q;
    logic fall;
    logic rise;
    logic start_ok;
    logic timeout;
    logic bit_one;
    logic bit_zero;
    logic enter_ack;
    logic drive_d;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;

    // Line edges; cnt_q is the time since the last edge
    assign fall = prev_q && !in_q;
    assign rise = !prev_q && in_q;
    assign start_ok = prev_q && (cnt_q >= CNT_W'(START_CYC - 1));
    assign timeout = cnt_q >= CNT_W'(BIT_MAX_CYCLES);
    assign bit_one = ows_dominates(cnt_q, low_len_q);
    assign bit_zero = ows_dominates(low_len_q, cnt_q);
    assign enter_ack = (state_q == ST_ACKWAIT) && !rise
                       && (cnt_q == CNT_W'(ACK_VALID_CYC - 1));
    // pull-down held for the fixed pulse length
    assign drive_d = enter_ack || ((state_q == ST_ACK)
                     && (cnt_q != CNT_W'(ACK_PULSE_CYCLES - 1)));

    // Pin sampling; idle level is high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            in_q <= ctrl_in;
            prev_q <= in_q;
        end
    end

    // edge-to-edge timer, free of any rate setting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (((fall || rise) && state_q != ST_ACK) || enter_ack) begin
            cnt_q <= '0;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            byte_idx_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            addr_q <= 8'h00;
            low_len_q <= '0;
            push_q <= 1'b0;
            push_data_q <= '0;
            ok_q <= 1'b0;
            drop_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            ok_q <= 1'b0;
            drop_q <= 1'b0;
            err_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // start interval only needed before data byte
                    if (fall && (!byte_idx_q || start_ok)) begin
                        state_q <= ST_LOW;
                        bit_cnt_q <= 4'h0;
                    end else if (fall) begin
                        state_q <= ST_ERR;
                        err_q <= 1'b1;
                    end else if (byte_idx_q && !in_q && timeout) begin
                        byte_idx_q <= 1'b0;
                        drop_q <= 1'b1;
                    end
                end
                ST_LOW: begin
                    if (rise) begin
                        low_len_q <= cnt_q;
                        state_q <= ST_HIGH;
                    end else if (timeout) begin
                        state_q <= ST_ERR;
                        err_q <= 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (fall) begin
                        if (!bit_one && !bit_zero) begin
                            state_q <= ST_ERR;
                            err_q <= 1'b1;
                        end else begin
                            shreg_q <= {shreg_q[BYTE_BITS-2:0], bit_one};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'(BYTE_BITS - 1)) begin
                                state_q <= ST_EOS;
                            end else begin
                                state_q <= ST_LOW;
                            end
                        end
                    end else if (timeout) begin
                        state_q <= ST_ERR;
                        err_q <= 1'b1;
                    end
                end
                ST_EOS: begin
                    // line must stay low for the end-of-stream time
                    if (rise) begin
                        state_q <= ST_ERR;
                        err_q <= 1'b1;
                    end else if (cnt_q == CNT_W'(EOS_CYC - 1)) begin
                        state_q <= ST_IDLE;
                        if (!byte_idx_q) begin
                            addr_q <= shreg_q;
                            byte_idx_q <= 1'b1;
                        end else begin
                            byte_idx_q <= 1'b0;
                            // address, room and flag gate the ack
                            if (addr_q == DEV_ADDR && fifo_in_ready) begin
                                push_q <= 1'b1;
                                push_data_q <= shreg_q[SUB_HI_POS:0];
                                ok_q <= 1'b1;
                                if (shreg_q[ACK_REQ_POS]) begin
                                    state_q <= ST_ACKWAIT;
                                end
                            end else begin
                                drop_q <= 1'b1;
                            end
                        end
                    end
                end
                ST_ACKWAIT: begin
                    // master releasing early abandons the ack
                    if (rise) begin
                        state_q <= ST_IDLE;
                    end else if (enter_ack) begin
                        state_q <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (!drive_d) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ERR: begin
                    // Resynchronise only after a long idle high
                    if (in_q && timeout) begin
                        state_q <= ST_IDLE;
                        byte_idx_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    byte_idx_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_n_q <= 1'b1;
            out_q <= 1'b0;
        end else begin
            oe_n_q <= !drive_d;
            out_q <= 1'b0;
        end
    end

    // Commands queue here while the consumer stalls; a frame arriving with the queue full is dropped
    ows_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(!level_hold),
        .out_data(fifo_out_data)
    );

    // level register, full scale after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_q <= LEVEL_RESET;
            sub_q <= '0;
            fb_q <= ows_fb_mv(LEVEL_RESET);
        end else if (fifo_out_valid && !level_hold) begin
            level_q <= fifo_out_data[LEVEL_MSB_POS:0];
            sub_q <= fifo_out_data[SUB_HI_POS:SUB_LO_POS];
            fb_q <= ows_fb_mv(fifo_out_data[LEVEL_MSB_POS:0]);
        end
    end

    // Busy while a frame or ack is in progress
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != ST_IDLE) || byte_idx_q;
        end
    end

    // Helper: length of the last pull-down, for checking only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_len_q <= '0;
        end else if (!oe_n_q) begin
            ack_len_q <= ack_len_q + 1'b1;
        end else if (!drive_d) begin
            ack_len_q <= ack_len_q;
        end else begin
            ack_len_q <= '0;
        end
    end

    assign ctrl_out = out_q;
    assign ctrl_oe_n = oe_n_q;
    assign level_code = level_q;
    assign sub_address = sub_q;
    assign feedback_reference_mv = fb_q;
    assign frame_ok = ok_q;
    assign frame_drop = drop_q;
    assign frame_err = err_q;
    assign rx_busy = busy_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_bit_end;
        state_q == ST_HIGH && fall;
    endsequence
    sequence s_ack_start;
        $fell(oe_n_q);
    endsequence

    AST_BIT_ONE: assert property (
        s_bit_end ##0 bit_one |=> shreg_q[0] && state_q != ST_ERR)
        else $error("one bit not decoded as one");
    AST_BIT_ZERO: assert property (
        s_bit_end ##0 bit_zero |=> !shreg_q[0] && state_q != ST_ERR)
        else $error("zero bit not decoded as zero");
    AST_BAD_RATIO: assert property (
        s_bit_end ##0 (!bit_one && !bit_zero) |=> state_q == ST_ERR ##1 !ok_q)
        else $error("bad ratio bit not rejected");
    AST_EOS_BREAK: assert property (
        state_q == ST_EOS && rise |=> state_q == ST_ERR && err_q)
        else $error("short end of stream accepted");
    AST_ACK_COND: assert property (
        s_ack_start |-> addr_q == DEV_ADDR && push_data_q == shreg_q[6:0]
        && shreg_q[ACK_REQ_POS])
        else $error("ack without its conditions");
    AST_ACK_DELAY: assert property (
        s_ack_start |-> $past(state_q) == ST_ACKWAIT
        && $past(cnt_q) == CNT_W'(ACK_VALID_CYC - 1))
        else $error("ack not after validity delay");
    AST_ACK_LEN: assert property (
        $rose(oe_n_q) |-> ack_len_q == CNT_W'(ACK_PULSE_CYCLES))
        else $error("ack pulse length wrong");
    AST_OD_LOW: assert property (
        !oe_n_q |-> !out_q ##1 !out_q)
        else $error("pin driven high");
    AST_LEVEL_RESET: assert property (
        $past(sys_rst) |-> level_q == LEVEL_RESET && fb_q == 8'hC8)
        else $error("level not full scale after reset");
    AST_ADDR_FIRST: assert property (
        state_q == ST_EOS && !byte_idx_q && cnt_q == CNT_W'(EOS_CYC - 1)
        && !rise |=> addr_q == $past(shreg_q) && byte_idx_q)
        else $error("address byte not captured first");

endmodule
`default_nettype wire

// [sim/one_wire_dimming_receiver_test.sv]
// Self-checking bench for the single-wire dimming receiver.
// Assumes the master model and a pull-up on the control line.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end end
module one_wire_dimming_receiver_test
    import ows_pkg::*;
;
    localparam int ACK_CYC = 64;
    localparam int BIT_MAX = 3000;
    localparam logic [7:0] ADDR = 8'h5A; // Arbitrary device address
    localparam int FB_MV [32] = '{0, 5, 8, 11, 14, 17, 20, 23, 26, 29, 32,
        35, 38, 44, 50, 56, 62, 68, 74, 80, 86, 92, 98, 104, 116, 128, 140,
        152, 164, 176, 188, 200};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic level_hold = 1'b0;
    logic pull_low, ctrl_out, ctrl_oe_n, frame_ok, frame_drop;
    logic frame_err, rx_busy, collect = 1'b0;
    logic [4:0] level_code, exp_lvl = 5'h1F, pend = 5'h1F;
    logic [1:0] sub_address;
    logic [7:0] feedback_reference_mv;
    logic [31:0] seed = 32'h0000_0021;
    logic [4:0] lv_q [$];
    logic [7:0] fb_q [$];
    int mismatches = 0, samples_checked = 0;
    int ok_cnt = 0, drop_cnt = 0, err_cnt = 0, ack_len = 0;
    // Wired-AND of both open-drain pulls with the pull-up
    wire logic line = !pull_low && ctrl_oe_n;

    always #2.5 clk = ~clk;

    ows_rx #(.ACK_PULSE_CYCLES(ACK_CYC), .BIT_MAX_CYCLES(BIT_MAX),
             .DEV_ADDR(ADDR)) ows_rx_i (.clk(clk), .sys_rst(sys_rst),
        .ctrl_in(line), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n),
        .level_hold(level_hold), .level_code(level_code),
        .sub_address(sub_address),
        .feedback_reference_mv(feedback_reference_mv),
        .frame_ok(frame_ok), .frame_drop(frame_drop),
        .frame_err(frame_err), .rx_busy(rx_busy));
    ows_master ows_master_i (.clk(clk), .line(line), .pull_low(pull_low));

    // Repeatable pseudo-random source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected reference step for a level code
    function automatic logic [7:0] fb_of(input logic [4:0] c);
        return 8'(FB_MV[c]);
    endfunction

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Pulse counts, ack length and drain capture, off the active edge
    always @(negedge clk) begin
        if (frame_ok === 1'b1) ok_cnt++;
        if (frame_drop === 1'b1) drop_cnt++;
        if (frame_err === 1'b1) err_cnt++;
        if (ctrl_oe_n === 1'b0) begin
            ack_len++;
            `CHK(ctrl_out, 1'b0)
        end else if (ack_len != 0) begin
            `CHK(ack_len, ACK_CYC)
            ack_len = 0;
        end
        if (collect && level_code !== lv_q[$]) lv_q.push_back(level_code);
        if (collect && feedback_reference_mv !== fb_q[$])
            fb_q.push_back(feedback_reference_mv);
    end

    // One frame with all its expectations; full marks a refused push
    task automatic run_frame(input logic [7:0] a, input logic [7:0] d,
                             input int u, input int k, input int bad,
                             input logic full);
        int ok0, dr0, er0;
        logic acked, good;
        ok0 = ok_cnt;
        dr0 = drop_cnt;
        er0 = err_cnt;
        good = (a === ADDR) && (bad < 0) && !full;
        ows_master_i.send_frame(a, d, u, k, bad, acked);
        // Receiver wants a long high line after an error
        if (bad >= 0) repeat (BIT_MAX + 100) @(posedge clk);
        if (good) pend = d[4:0];
        if (good && !level_hold) exp_lvl = pend;
        `CHK(acked, good && d[7])
        `CHK(ok_cnt - ok0, int'(good))
        `CHK(drop_cnt - dr0, int'(a !== ADDR || full))
        `CHK(err_cnt - er0, int'(bad >= 0))
        `CHK(level_code, exp_lvl)
        `CHK(feedback_reference_mv, fb_of(exp_lvl))
        `CHK(rx_busy, 1'b0)
    endtask

    initial begin
        logic [31:0] r;
        logic [7:0] a;
        int bad;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(level_code, 5'h1F)
        `CHK(feedback_reference_mv, 8'hC8)
        `CHK({ctrl_oe_n, rx_busy, sub_address}, 4'h8)
        // Corners: exact 2x ratio, top bit rate, wrong address, bad bit
        run_frame(ADDR, 8'h80, 6, 2, -1, 1'b0);
        run_frame(ADDR, 8'h95, 417, 2, -1, 1'b0);
        run_frame(ADDR ^ 8'h01, 8'h83, 6, 3, -1, 1'b0);
        run_frame(ADDR, 8'h8A, 6, 3, 0, 1'b0);
        // Stall the consumer, fill (until refused on the first pass, to depth on the second), then drain
        for (int f = 0; f < 2; f++) begin
            level_hold <= 1'b1;
            for (int c = 0; c < 17 - f; c++)
                run_frame(ADDR, 8'(16 * f + c), 4, 2, -1, c == 16);
            lv_q = {level_code};
            fb_q = {feedback_reference_mv};
            collect = 1'b1;
            level_hold <= 1'b0;
            exp_lvl = pend;
            repeat (40) @(posedge clk);
            collect = 1'b0;
            `CHK(lv_q.size(), 17)
            for (int i = 0; i < 16; i++) begin
                `CHK(lv_q[i + 1], 5'(16 * f + i))
                `CHK(fb_q[i + 1], fb_of(5'(16 * f + i)))
            end
        end
        // Random rates, ratios, flags, addresses and broken bits
        for (int n = 0; n < 4; n++) begin
            r = xs();
            a = (r[30:28] == 3'h0) ? ~ADDR : ADDR;
            bad = (r[20:18] == 3'h0 && a == ADDR) ? int'(r[23:21]) : -1;
            run_frame(a, {r[7], 2'b00, r[4:0]}, 4 + int'(r[12:8]),
                      2 + int'(r[16]), bad, 1'b0);
        end
        finish_test();
    end

    // Watchdog a little above the longest expected run
    initial begin
        repeat (110000) @(posedge clk);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire

// [sim/ows_master.sv]
// Link master model: an open-drain driver of the control line.
// Assumes the bench resolves the wire with a pull-up and calls the
// tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ows_master
    import ows_pkg::*;
(
    // Clock and resolved line
    input wire logic clk,
    input wire logic line,
    output logic pull_low
);
    initial pull_low = 1'b0;

    // Drive one level for n cycles
    task automatic hold(input logic low, input int n);
        pull_low <= low;
        repeat (n) @(posedge clk);
    endtask

    // One byte; the closing fall is left to the caller
    task automatic send_byte(input logic [7:0] v, input int u, input int k,
                             input int bad);
        int m;
        // MSB first, ratio coded, k=1 breaks the ratio
        for (int i = 7; i >= 0; i--) begin
            m = (i == bad) ? 1 : k;
            hold(1'b1, v[i] ? u : m * u);
            hold(1'b0, v[i] ? m * u : u);
        end
    endtask

    // Whole frame; acked tells whether the line read back low
    task automatic send_frame(input logic [7:0] a, input logic [7:0] d,
                              input int u, input int k, input int bad,
                              output logic acked);
        // idle high line, no start before address
        send_byte(a, u, k, -1);
        // end of stream closes the byte
        hold(1'b1, EOS_CYC + 20);
        hold(1'b0, START_CYC + 20);
        send_byte(d, u, k, bad);
        acked = 1'b0;
        if (d[ACK_REQ_POS]) begin
            // low through validity delay, then read back
            hold(1'b1, ACK_VALID_CYC + 40);
            hold(1'b0, 3);
            acked = !line;
            for (int n = 0; n < 4000 && !line; n++) @(posedge clk);
        end else begin
            hold(1'b1, EOS_CYC + 20);
        end
        hold(1'b0, 40);
    endtask
endmodule
`default_nettype wire
